// ==== src/fspc_defs.svh ====
`ifndef FSPC_DEFS_SVH
`define FSPC_DEFS_SVH
//
// Contract
// - watch five faults; any one raises the alarm.
// - alarm flag either self-clears with the fault or stays latched.
// - level sequence mode holds up to 16 elements of 14 bits.
// - parallel mode output follows each code transfer on the bus.
// - armed protection shuts the device down on alarm; code does so only while the sleep bit is 1 and min_alarm_cycles is not 0.
// - disarmed protection ignores alarms, no shutdown from them.
// - alarm is immediate; shutdown only after adjustable minimum duration.
// - shutdown on user pulse of shutdown pin or long alarm.
// - release pin pulsed high then low exits shutdown.
// - restart bit written high then low exits shutdown.
// - sleep bit 0 enters sleep, 1 leaves; not latching.
// - sleep overrides every shutdown pin request.
// - shutdown pin is bidirectional, active high, input and indication.
// - each strobe in sequence mode steps to next stored level; code refuses a strobe while both buffer slots are full.
// - each strobe in parallel mode applies the 14-bit bus code; code refuses a strobe while both buffer slots are full.
`define FSPC_NUM_FAULTS 5
`define FSPC_CODE_W 14
`define FSPC_DEPTH 16
`define FSPC_PTR_W 4
`define FSPC_DUR_W 16
`define FSPC_DUR_DEFAULT 16'h0064
`define FSPC_FLT_SRC_OC 0
`define FSPC_FLT_SNK_OC 1
`define FSPC_FLT_POS_OV 2
`define FSPC_FLT_NEG_OV 3
`define FSPC_FLT_OT 4
`endif

// ==== src/fspc_pkg.sv ====
package fspc_pkg;
  `include "fspc_defs.svh"
  typedef enum logic {
    FSPC_MODE_SEQ,
    FSPC_MODE_PAR
  } fspc_mode_type;
  typedef enum logic [1:0] {
    FSPC_RUN,
    FSPC_SDN,
    FSPC_SDN_REL
  } fspc_st_type;
  typedef struct packed {
    logic [`FSPC_PTR_W-1:0] addr;
    logic [`FSPC_CODE_W-1:0] code;
  } fspc_wr_type;
  typedef struct packed {
    logic [`FSPC_CODE_W-1:0] d0;
    logic [`FSPC_CODE_W-1:0] d1;
    logic [1:0] cnt;
    logic [`FSPC_PTR_W-1:0] ptr;
    logic [`FSPC_NUM_FAULTS-1:0] alarm;
    logic [`FSPC_DUR_W-1:0] dur;
    fspc_st_type st;
    logic restart_seen;
    logic pin_low_seen;
    logic pin_prev;
    logic rel_prev;
  } fspc_state_type;
endpackage : fspc_pkg

// ==== src/fspc_top.sv ====
`timescale 1ns/1ps
`include "fspc_defs.svh"
module fspc_top #(
  parameter int DEPTH = `FSPC_DEPTH
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [`FSPC_NUM_FAULTS-1:0] fault_in,
  input wire logic alarm_latch_en,
  input wire logic alarm_clear,
  input wire logic armed,
  input wire logic [`FSPC_DUR_W-1:0] min_alarm_cycles,
  input wire fspc_pkg::fspc_mode_type mode,
  input wire logic pat_wr,
  input wire fspc_pkg::fspc_wr_type pat_wr_data,
  input wire logic [`FSPC_PTR_W-1:0] pat_last,
  input wire logic [`FSPC_CODE_W-1:0] parallel_code_bus,
  input wire logic update_strobe,
  input wire logic driver_restart_bit,
  input wire logic driver_sleep_bit,
  input wire logic shutdown_release_pin,
  input wire logic shutdown_io_pin_i,
  input wire logic shutdown_io_pin_oe_n_ext,
  output logic shutdown_io_pin_o,
  output logic shutdown_io_pin_oe,
  output logic [`FSPC_NUM_FAULTS-1:0] alarm_flags,
  output logic alarm_any,
  output logic in_shutdown,
  output logic in_sleep,
  output logic out_enable,
  output logic out_valid,
  input wire logic out_ready,
  output logic [`FSPC_CODE_W-1:0] out_code,
  output logic strobe_ready
);
  import fspc_pkg::*;

  // ****************************************
  // pattern memory
  // ****************************************
  logic [`FSPC_CODE_W-1:0] mem_q [DEPTH];
  // host writes whenever it likes; a write during stepping is its own risk
  always_ff @(posedge mclk) begin
    if (pat_wr) begin
      mem_q[pat_wr_data.addr] <= pat_wr_data.code;
    end
  end

  // ****************************************
  // state
  // ****************************************
  fspc_state_type s_q, s_d;
  logic strobe_take, pin_req, pin_low_now, rel_fall, rst_fall;
  logic [`FSPC_CODE_W-1:0] new_code;

  // pin request: external high level while this device is not driving the pin
  assign pin_req = shutdown_io_pin_i & ~shutdown_io_pin_oe;
  // taken from the host's own pull-down flag, not the resolved wire,
  // so the output enable never loops back through the wire level
  assign pin_low_now = ~shutdown_io_pin_oe_n_ext;
  assign rel_fall = s_q.rel_prev & ~shutdown_release_pin;
  assign rst_fall = s_q.restart_seen & ~driver_restart_bit;
  // buffer stalls the strobe only when both slots hold words
  assign strobe_ready = (s_q.cnt != 2'd2);
  assign strobe_take = update_strobe & strobe_ready;
  // sequence reads stored level, parallel takes bus
  assign new_code = (mode == FSPC_MODE_SEQ) ? mem_q[s_q.ptr] :
                    parallel_code_bus;

  // next state
  always_comb begin
    s_d = s_q;
    s_d.rel_prev = shutdown_release_pin;
    s_d.pin_prev = shutdown_io_pin_i;
    // alarms: set wins over clear
    for (int i = 0; i < `FSPC_NUM_FAULTS; i++) begin
      if (fault_in[i]) begin
        s_d.alarm[i] = 1'b1;
      end else if (!alarm_latch_en || alarm_clear) begin
        s_d.alarm[i] = 1'b0;
      end
    end
    // duration counter runs while any fault is present and armed
    if (armed && (|fault_in)) begin
      if (s_q.dur != {`FSPC_DUR_W{1'b1}}) begin
        s_d.dur = s_q.dur + 1'b1;
      end
    end else begin
      s_d.dur = '0;
    end
    if (driver_restart_bit) begin
      s_d.restart_seen = 1'b1;
    end else begin
      s_d.restart_seen = 1'b0;
    end
    if (pin_low_now) begin
      s_d.pin_low_seen = 1'b1;
    end
    // shutdown state machine
    case (s_q.st)
      FSPC_RUN: begin
        s_d.pin_low_seen = 1'b0;
        if (driver_sleep_bit && (pin_req ||
            (armed && s_q.dur >= min_alarm_cycles &&
             min_alarm_cycles != '0))) begin
          s_d.st = FSPC_SDN;
        end
      end
      FSPC_SDN: begin
        if (rel_fall || rst_fall) begin
          s_d.st = FSPC_SDN_REL;
        end else if (s_q.pin_low_seen && !pin_low_now) begin
          s_d.st = FSPC_SDN_REL;
        end
      end
      FSPC_SDN_REL: begin
        // one cycle gap so the driven indication drops before rechecking
        s_d.st = FSPC_RUN;
        s_d.dur = '0;
      end
      default: begin
        s_d.st = FSPC_RUN;
      end
    endcase
    // output buffer: pop then push
    if (s_q.cnt != 2'd0 && out_ready) begin
      s_d.d0 = s_q.d1;
      s_d.cnt = s_q.cnt - 2'd1;
    end
    if (strobe_take) begin
      if (s_d.cnt == 2'd0) begin
        s_d.d0 = new_code;
      end else begin
        s_d.d1 = new_code;
      end
      s_d.cnt = s_d.cnt + 2'd1;
      if (mode == FSPC_MODE_SEQ) begin
        if (s_q.ptr >= pat_last) begin
          s_d.ptr = '0;
        end else begin
          s_d.ptr = s_q.ptr + 1'b1;
        end
      end
    end
    if (!rst_n) begin
      s_d = '0;
      s_d.st = FSPC_SDN;
    end
  end

  // registers
  always_ff @(posedge mclk) begin
    s_q <= s_d;
  end

  // ****************************************
  // outputs
  // ****************************************
  assign alarm_flags = s_q.alarm;
  assign alarm_any = |s_q.alarm;
  assign in_sleep = ~driver_sleep_bit;
  assign in_shutdown = (s_q.st == FSPC_SDN);
  assign out_enable = ~in_shutdown & driver_sleep_bit;
  // drive high to indicate shutdown while the host is not pulling low, float otherwise
  assign shutdown_io_pin_oe = (s_q.st == FSPC_SDN) && !pin_low_now;
  assign shutdown_io_pin_o = 1'b1;
  assign out_valid = (s_q.cnt != 2'd0);
  assign out_code = s_q.d0;
endmodule : fspc_top

// ==== dv/fspc_monitor.sv ====
`timescale 1ns/1ps
module fspc_monitor (
  input logic mclk, rst_n, alarm_latch_en, alarm_clear, driver_sleep_bit,
  input logic alarm_any, in_shutdown, in_sleep, out_enable, out_valid,
  input logic out_ready,
  input logic [4:0] fault_in, alarm_flags,
  input logic [13:0] out_code
);
  // ****
  // alarm, shutdown and output checks
  // ****
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // a word waiting on a stalled sink
  sequence held_s; out_valid && !out_ready; endsequence
  alarm_or_a: assert property (alarm_any == |alarm_flags)
    else $error("alarm_any wrong");
  alarm_set_a: assert property (fault_in != 0 |=>
    (alarm_flags & $past(fault_in)) == $past(fault_in)) else $error("no flag");
  self_clear_a: assert property (!alarm_latch_en && !fault_in
    |=> !alarm_flags) else $error("no self clear");
  latch_hold_a: assert property (alarm_latch_en && !alarm_clear
    |=> !($past(alarm_flags) & ~alarm_flags)) else $error("latch lost");
  sleep_block_a: assert property (!driver_sleep_bit && !in_shutdown
    |=> !in_shutdown) else $error("shutdown in sleep");
  sleep_out_a: assert property (!driver_sleep_bit
    |-> in_sleep && !out_enable) else $error("sleep ignored");
  sdn_out_a: assert property (in_shutdown |-> !out_enable)
    else $error("output on");
  word_stand_a: assert property (held_s
    |=> out_valid && $stable(out_code)) else $error("word dropped");
endmodule : fspc_monitor

// ==== dv/fspc_host.sv ====
`timescale 1ns/1ps
module fspc_host (
  input logic stall, pull_low, push_high, oe,
  output logic out_ready, pin_i, oe_n_ext
);
  // ****
  // host side of the stream and the shutdown wire
  // ****
  // stalls on demand, so the buffer has to hold words
  assign out_ready = !stall;
  assign oe_n_ext = !pull_low;
  // weak pull-down: a floated wire reads low, never a stale value
  assign pin_i = pull_low ? 1'b0 : oe | push_high;
endmodule : fspc_host

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  import fspc_pkg::*;
  logic mclk, rst_n, alarm_latch_en, alarm_clear, armed, pat_wr, stall;
  logic update_strobe, driver_restart_bit, driver_sleep_bit, pull_low;
  logic shutdown_release_pin, shutdown_io_pin_i, shutdown_io_pin_oe_n_ext;
  logic shutdown_io_pin_o, shutdown_io_pin_oe, alarm_any, in_shutdown;
  logic in_sleep, out_enable, out_valid, out_ready, strobe_ready, push_high;
  logic [4:0] fault_in, alarm_flags;
  logic [15:0] min_alarm_cycles;
  logic [3:0] pat_last;
  logic [13:0] parallel_code_bus, out_code, got[$];
  logic [13:0] exp_w[5] = '{14'h0A00, 14'h0A01, 14'h0A02, 14'h0A00, 14'h3FFF};
  fspc_mode_type mode;
  fspc_wr_type pat_wr_data;
  int num_errors, checks;
  fspc_top u_fspc_top (.*);
  fspc_host u_fspc_host (.stall, .pull_low, .push_high, .out_ready,
    .oe(shutdown_io_pin_oe), .pin_i(shutdown_io_pin_i),
    .oe_n_ext(shutdown_io_pin_oe_n_ext));
  // ****
  // clock, sink, tasks and tests
  // ****
  initial begin
    mclk = 0;
    forever #5 mclk = ~mclk;
  end
  // every accepted word is kept for one ordered compare
  always @(posedge mclk)
    if (out_valid === 1'b1 && out_ready) got.push_back(out_code);
  task automatic chk(string n, logic [13:0] e, logic [13:0] g);
    checks++;
    if (g !== e) begin
      $display("FAIL %s exp %h got %h", n, e, g);
      num_errors++;
    end
  endtask : chk
  task automatic step(int n);
    repeat (n) @(negedge mclk);
  endtask : step
  // one-cycle high pulse, then time to settle
  task automatic pulse(ref logic s);
    s = 1;
    step(1);
    s = 0;
    step(3);
  endtask : pulse
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  initial begin
    {fault_in, alarm_latch_en, alarm_clear, armed, pat_wr, pull_low} = 0;
    {update_strobe, driver_restart_bit, shutdown_release_pin, stall} = 0;
    {push_high, rst_n, pat_wr_data, num_errors, checks} = 0;
    {driver_sleep_bit, pat_last, min_alarm_cycles} = {5'h12, 16'h0005};
    parallel_code_bus = 14'h3FFF;
    mode = FSPC_MODE_SEQ;
    step(4);
    rst_n = 1;
    chk("flags", 0, alarm_flags);
    pulse(shutdown_release_pin);
    chk("release", 0, in_shutdown);
    pat_wr = 1;
    for (int i = 0; i < 3; i++) begin
      pat_wr_data = '{4'(i), 14'h0A00 + 14'(i)};
      step(1);
    end
    // third strobe meets a full buffer and must be refused
    {pat_wr, stall, update_strobe} = 3'b011;
    step(2);
    chk("full", 0, strobe_ready);
    step(1);
    {stall, update_strobe} = 0;
    step(3);
    update_strobe = 1;
    step(2);
    mode = FSPC_MODE_PAR;
    step(1);
    update_strobe = 0;
    step(4);
    chk("count", 5, 14'(got.size()));
    foreach (exp_w[i]) chk("word", exp_w[i], got[i]);
    $display("stream test done");
    {alarm_latch_en, armed, fault_in} = 7'h61;
    step(1);
    chk("early", 0, in_shutdown);
    step(8);
    chk("trip", 1, in_shutdown);
    fault_in = 0;
    step(2);
    chk("latched", 1, alarm_flags);
    pulse(alarm_clear);
    chk("cleared", 0, alarm_flags);
    pulse(driver_restart_bit);
    chk("restart", 0, in_shutdown);
    {alarm_latch_en, armed, fault_in} = 7'h1F;
    step(9);
    chk("disarmed", 0, in_shutdown);
    {driver_sleep_bit, fault_in} = 0;
    pulse(push_high);
    chk("sleep", 0, in_shutdown);
    driver_sleep_bit = 1;
    pulse(push_high);
    chk("user", 1, in_shutdown);
    chk("pin", 1, shutdown_io_pin_i);
    pulse(pull_low);
    chk("low exit", 0, in_shutdown);
    $display("shutdown test done");
    end_sim;
  end
  // the whole run needs about 640 nanoseconds
  initial begin
    #5us;
    num_errors++;
    end_sim;
  end
endmodule : testbench
bind fspc_top fspc_monitor u_fspc_monitor (.*);
